// ### crs_top.sv
// Clock selection, CPU clock tick generation and reset sequencing, with APB registers.
// Assumes option inputs are static straps, the reset pin is resolved outside, the watchdog is on pclk.
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "crs_params.svh"
module crs_top
  import crs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic opt_pll_en,
  input wire logic [2:0] opt_osc_sel,
  input wire logic opt_long_delay,
  input wire logic clock_input_pin,
  input wire logic resonator_input_pin,
  output logic resonator_output_pin,
  output logic [3:0] osc_enable,
  input wire logic reset_pin_i,
  output logic reset_pin_o,
  output logic reset_pin_oe,
  input wire logic watchdog_underflow,
  output logic cpu_clock_tick,
  output logic cpu_reset_n,
  output logic [15:0] vector_addr,
  output logic vector_fetch
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  crs_state_t state_r;
  crs_state_t state_nxt;
  crs_src_t src_sel;
  crs_dly_if dly ();

  logic ext_hit_r;
  logic [7:0] sync_d;
  logic [7:0] sync_q;
  logic opt_pll_s;
  logic [2:0] opt_sel_s;
  logic opt_long_s;
  logic clk_in_s;
  logic res_in_s;
  logic ext_hit_s;
  logic pin_low_s;

  logic osc_s;
  logic osc_prev_r;
  logic osc_rise;
  logic osc_fall;
  logic div_r;
  logic [6:0] per_cnt_r;
  logic pll_ok_r;
  logic pll_active;
  logic tick;

  logic [7:0] wdg_cnt_r;
  logic fetch_idx_r;
  logic [2:0] guard_r;
  logic ext_req;
  logic wdg_req;

  logic [7:0] sys_status_r;
  logic [3:0] evt_r;
  logic [3:0] evt_mask_r;
  logic [3:0] evt_set;
  logic pll_ok_prev_r;
  logic wr_en;
  logic rd_en;
  logic addr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Reset pin catch and synchronisers

  // Pin low acts without a clock; flop stays set until an edge sees it high
  always_ff @(posedge pclk or negedge reset_pin_i) begin
    if (!reset_pin_i) begin
      ext_hit_r <= 1'b1;
    end else begin
      ext_hit_r <= 1'b0;
    end
  end

  // Catch flop carried inverted so the synchroniser reset value reads as a hit
  assign sync_d = {~ext_hit_r, resonator_input_pin, clock_input_pin,
                   opt_long_delay, opt_osc_sel, opt_pll_en};

  crs_sync #(.W(8)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(sync_d),
    .q(sync_q)
  );

  assign opt_pll_s = sync_q[0];
  assign opt_sel_s = sync_q[3:1];
  assign opt_long_s = sync_q[4];
  assign clk_in_s = sync_q[5];
  assign res_in_s = sync_q[6];
  assign ext_hit_s = !sync_q[7];
  assign pin_low_s = ext_hit_s;

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator selection

  assign src_sel = crs_src_t'(opt_sel_s);
  assign osc_s = (src_sel == CRS_SRC_EXT) ? clk_in_s : res_in_s;

  // Resonator stays enabled in every sequencer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_enable <= 4'h0;
    end else begin
      case (src_sel)
        CRS_SRC_RES0: osc_enable <= 4'h1;
        CRS_SRC_RES1: osc_enable <= 4'h2;
        CRS_SRC_RES2: osc_enable <= 4'h4;
        CRS_SRC_RES3: osc_enable <= 4'h8;
        default: osc_enable <= 4'h0;
      endcase
    end
  end

  // Inverting amplifier stand-in; output held low in external clock mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resonator_output_pin <= 1'b0;
    end else begin
      resonator_output_pin <= (src_sel != CRS_SRC_EXT) && !res_in_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // CPU clock: doubled by the PLL or divided by two

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_prev_r <= 1'b0;
    end else begin
      osc_prev_r <= osc_s;
    end
  end

  assign osc_rise = osc_s && !osc_prev_r;
  assign osc_fall = !osc_s && osc_prev_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 1'b0;
    end else if (osc_rise) begin
      div_r <= ~div_r;
    end
  end

  // Input period check; PLL used only while the input lies in its range
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_cnt_r <= 7'h00;
    end else if (osc_rise) begin
      per_cnt_r <= 7'h01;
    end else if (per_cnt_r != 7'h7F) begin
      per_cnt_r <= per_cnt_r + 7'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_ok_r <= 1'b0;
    end else if (osc_rise) begin
      pll_ok_r <= (per_cnt_r >= 7'(`CRS_PLL_PER_MIN)) && (per_cnt_r <= 7'(`CRS_PLL_PER_MAX));
    end else if (per_cnt_r == 7'h7F) begin
      pll_ok_r <= 1'b0;
    end
  end

  assign pll_active = opt_pll_s && pll_ok_r;
  assign tick = pll_active ? (osc_rise | osc_fall) : (osc_rise & div_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clock_tick <= 1'b0;
    end else begin
      cpu_clock_tick <= tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset sequence

  assign dly.run = (state_r == CRS_ST_DELAY);
  assign dly.long_sel = opt_long_s;
  assign dly.tick = tick;

  crs_delay_ctr u_dly (
    .pclk(pclk),
    .presetn(presetn),
    .dly(dly)
  );

  // Own pin drive and its echo are ignored until the guard expires
  assign ext_req = ext_hit_s && !reset_pin_oe && (guard_r == 3'h0);
  assign wdg_req = watchdog_underflow && ((state_r == CRS_ST_RUN) || (state_r == CRS_ST_FETCH));

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CRS_ST_RUN: begin
        if (wdg_req) begin
          state_nxt = CRS_ST_ACT_WDG;
        end else if (ext_req) begin
          state_nxt = CRS_ST_ACT_EXT;
        end
      end
      CRS_ST_ACT_EXT: begin
        if (!ext_hit_s) begin
          state_nxt = CRS_ST_DELAY;
        end
      end
      CRS_ST_ACT_WDG: begin
        if (wdg_cnt_r == 8'h01) begin
          state_nxt = CRS_ST_DELAY;
        end
      end
      CRS_ST_DELAY: begin
        if (dly.done) begin
          state_nxt = CRS_ST_FETCH;
        end
      end
      CRS_ST_FETCH: begin
        if (wdg_req) begin
          state_nxt = CRS_ST_ACT_WDG;
        end else if (ext_req) begin
          state_nxt = CRS_ST_ACT_EXT;
        end else if (tick && fetch_idx_r) begin
          state_nxt = CRS_ST_RUN;
        end
      end
      default: state_nxt = CRS_ST_ACT_EXT;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= CRS_ST_ACT_EXT;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdg_cnt_r <= 8'h00;
    end else if (state_nxt == CRS_ST_ACT_WDG && state_r != CRS_ST_ACT_WDG) begin
      wdg_cnt_r <= 8'(`CRS_WDG_PULSE_CYC);
    end else if (wdg_cnt_r != 8'h00) begin
      wdg_cnt_r <= wdg_cnt_r - 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_pin_oe <= 1'b0;
    end else begin
      reset_pin_oe <= (state_nxt == CRS_ST_ACT_WDG) || (state_nxt == CRS_ST_DELAY);
    end
  end

  assign reset_pin_o = 1'b0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      guard_r <= 3'h0;
    end else if (reset_pin_oe) begin
      guard_r <= 3'(`CRS_REL_GUARD);
    end else if (guard_r != 3'h0) begin
      guard_r <= guard_r - 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_idx_r <= 1'b0;
    end else if (state_r != CRS_ST_FETCH) begin
      fetch_idx_r <= 1'b0;
    end else if (tick) begin
      fetch_idx_r <= 1'b1;
    end
  end

  // One fetch strobe per CPU tick: low byte then high byte of the vector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_addr <= 16'h0000;
      vector_fetch <= 1'b0;
    end else begin
      vector_fetch <= (state_r == CRS_ST_FETCH) && tick && (state_nxt != CRS_ST_ACT_WDG)
                      && (state_nxt != CRS_ST_ACT_EXT);
      if (state_r == CRS_ST_FETCH && tick) begin
        vector_addr <= fetch_idx_r ? `CRS_VEC_HI : `CRS_VEC_LO;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_reset_n <= 1'b0;
    end else begin
      cpu_reset_n <= (state_nxt == CRS_ST_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave and registers

  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign addr_ok = (paddr == `CRS_OFS_SYS_STATUS) || (paddr == `CRS_OFS_EVT_STATUS)
                   || (paddr == `CRS_OFS_EVT_MASK) || (paddr == `CRS_OFS_SEQ_INFO);
  assign pslverr = psel && penable && !addr_ok;

  // Watchdog flag: hardware set wins over a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_status_r <= `CRS_SYS_STATUS_RST;
    end else if (state_nxt == CRS_ST_ACT_WDG && state_r != CRS_ST_ACT_WDG) begin
      sys_status_r[`CRS_WDG_FLAG_BIT] <= 1'b1;
    end else if (wr_en && paddr == `CRS_OFS_SYS_STATUS && !pwdata[`CRS_WDG_FLAG_BIT]) begin
      sys_status_r[`CRS_WDG_FLAG_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_ok_prev_r <= 1'b0;
    end else begin
      pll_ok_prev_r <= pll_ok_r;
    end
  end

  assign evt_set[`CRS_EVT_WDG_BIT] = (state_nxt == CRS_ST_ACT_WDG) && (state_r != CRS_ST_ACT_WDG);
  assign evt_set[`CRS_EVT_EXT_BIT] = (state_nxt == CRS_ST_ACT_EXT) && (state_r != CRS_ST_ACT_EXT);
  assign evt_set[`CRS_EVT_DONE_BIT] = (state_nxt == CRS_ST_RUN) && (state_r == CRS_ST_FETCH);
  assign evt_set[`CRS_EVT_PLL_BIT] = opt_pll_s && pll_ok_prev_r && !pll_ok_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_r <= `CRS_EVT_RST;
    end else if (wr_en && paddr == `CRS_OFS_EVT_STATUS) begin
      evt_r <= (evt_r & ~pwdata[3:0]) | evt_set;
    end else begin
      evt_r <= evt_r | evt_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_mask_r <= `CRS_EVT_RST;
    end else if (wr_en && paddr == `CRS_OFS_EVT_MASK) begin
      evt_mask_r <= pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evt_r & evt_mask_r);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (paddr)
        `CRS_OFS_SYS_STATUS: prdata <= {24'h00_0000, sys_status_r};
        `CRS_OFS_EVT_STATUS: prdata <= {28'h000_0000, evt_r};
        `CRS_OFS_EVT_MASK: prdata <= {28'h000_0000, evt_mask_r};
        `CRS_OFS_SEQ_INFO: prdata <= {20'h0_0000, pin_low_s, pll_ok_r, pll_active, opt_long_s,
                                      1'b0, opt_sel_s, 1'b0, state_r};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// ### crs_params.svh
// Constants of the clock and reset sequencer: offsets, fields, reset values, counts.
// Assumes a 125 MHz APB clock and a 16-bit program address space.
// Notes on behaviour
// - With the PLL in use and a 2 to 4 MHz input, the CPU clock runs at twice the input, 4 to 8 MHz.
// - The PLL is switched on by the option setting while the input period lies in its range; otherwise the CPU clock is the oscillator divided by 2.
// - The main clock comes from the external clock input or one of 4 resonator oscillators, chosen by option.
// - The selected resonator keeps running through reset, so no start-up time is added when reset ends.
// - External and watchdog resets both act on the reset pin, which is held low for the whole delay phase.
// - After reset the reset routine address is fetched from the top two bytes of memory.
// - Each reset runs three phases in order: source-dependent active phase, stabilisation delay, vector fetch.
// - The stabilisation delay lasts 256 or 4096 CPU clock cycles, chosen by the option setting.
// - The vector fetch takes exactly 2 clock cycles before execution starts at the fetched address.
// - The reset pin is an input plus an open-drain output with a weak pull-up; outside logic may pull it low.
// - A low pulse on the reset pin is caught without a running clock, so reset is entered even in halt.
// - On watchdog underflow the pin is driven low for at least the minimum watchdog reset pulse width.
// - The watchdog reset flag in bit 0 of the system integrity status is set by a watchdog reset, cleared by writing 0.
`ifndef CRS_PARAMS_SVH
`define CRS_PARAMS_SVH

`define CRS_OFS_SYS_STATUS 8'h00
`define CRS_OFS_EVT_STATUS 8'h04
`define CRS_OFS_EVT_MASK 8'h08
`define CRS_OFS_SEQ_INFO 8'h0C

`define CRS_SYS_STATUS_RST 8'h00
`define CRS_EVT_RST 4'h0
`define CRS_WDG_FLAG_BIT 0
`define CRS_EVT_WDG_BIT 0
`define CRS_EVT_EXT_BIT 1
`define CRS_EVT_DONE_BIT 2
`define CRS_EVT_PLL_BIT 3

`define CRS_PCLK_KHZ 125000
`define CRS_PLL_FMIN_KHZ 2000
`define CRS_PLL_FMAX_KHZ 4000
`define CRS_PLL_PER_MAX (`CRS_PCLK_KHZ / `CRS_PLL_FMIN_KHZ)
`define CRS_PLL_PER_MIN ((`CRS_PCLK_KHZ + `CRS_PLL_FMAX_KHZ - 1) / `CRS_PLL_FMAX_KHZ)

`define CRS_DLY_SHORT 256
`define CRS_DLY_LONG 4096
`define CRS_FETCH_CYC 2
`define CRS_VEC_LO 16'hFFFE
`define CRS_VEC_HI 16'hFFFF

`define CRS_WDG_PULSE_NS 1000
`define CRS_WDG_PULSE_CYC ((`CRS_WDG_PULSE_NS * 125 + 999) / 1000)
`define CRS_REL_GUARD 4

`endif

// ### crs_pkg.sv
// Types of the clock and reset sequencer.
// Assumes crs_params.svh supplies the numeric constants.
package crs_pkg;

  typedef enum logic [2:0] {
    CRS_ST_RUN = 3'b000,
    CRS_ST_ACT_EXT = 3'b001,
    CRS_ST_ACT_WDG = 3'b010,
    CRS_ST_DELAY = 3'b011,
    CRS_ST_FETCH = 3'b100
  } crs_state_t;

  typedef enum logic [2:0] {
    CRS_SRC_EXT = 3'b000,
    CRS_SRC_RES0 = 3'b001,
    CRS_SRC_RES1 = 3'b010,
    CRS_SRC_RES2 = 3'b011,
    CRS_SRC_RES3 = 3'b100
  } crs_src_t;

endpackage

// ### crs_dly_if.sv
// Link between the sequencer and its stabilisation delay counter.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
interface crs_dly_if;
  logic run;
  logic long_sel;
  logic tick;
  logic done;
  modport ctl (output run, output long_sel, output tick, input done);
  modport ctr (input run, input long_sel, input tick, output done);
endinterface

// ### crs_sync.sv
// Two-flop synchroniser, one stage pair per bit.
// Assumes inputs are asynchronous to pclk.
`timescale 1ns/1ps
module crs_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_r;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_r <= 1'b0;
          q[i] <= 1'b0;
        end else begin
          meta_r <= d[i];
          q[i] <= meta_r;
        end
      end
    end
  endgenerate
endmodule

// ### crs_delay_ctr.sv
// Stabilisation delay counter, advanced by CPU clock ticks.
// Assumes run stays high for the whole delay phase.
`timescale 1ns/1ps
`include "crs_params.svh"
module crs_delay_ctr
  import crs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  crs_dly_if.ctr dly
);
  logic [11:0] cnt_r;
  logic [11:0] last;

  assign last = dly.long_sel ? 12'(`CRS_DLY_LONG - 1) : 12'(`CRS_DLY_SHORT - 1);
  assign dly.done = dly.run && dly.tick && (cnt_r == last);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 12'h000;
    end else if (!dly.run) begin
      cnt_r <= 12'h000;
    end else if (dly.tick) begin
      cnt_r <= cnt_r + 12'h001;
    end
  end
endmodule

// ### crs_top_sva.sv
// Concurrent checks on the clock and reset sequencer's top-level ports.
// Assumes a bind to crs_top and a single pclk domain.
`timescale 1ns/1ps
`include "crs_params.svh"
module crs_top_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic opt_long_delay,
  input wire logic [3:0] osc_enable,
  input wire logic reset_pin_i,
  input wire logic reset_pin_o,
  input wire logic reset_pin_oe,
  input wire logic watchdog_underflow,
  input wire logic cpu_clock_tick,
  input wire logic cpu_reset_n,
  input wire logic [15:0] vector_addr,
  input wire logic vector_fetch
);
  logic [12:0] tick_cnt_r;
  logic [19:0] oe_cyc_r;
  logic oe_d_r;
  logic [12:0] dly_lo;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign dly_lo = opt_long_delay ? 13'h1000 : 13'h0100;
  ////////////////////////////////////////////////////////////
  // Ticks and cycles spent with the pin pulled low
  // Tick output lags a cycle, so ticks are counted against the delayed pin drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_d_r <= 1'b0;
      tick_cnt_r <= 13'h0;
    end else begin
      oe_d_r <= reset_pin_oe;
      if (!oe_d_r) begin
        tick_cnt_r <= 13'h0;
      end else begin
        tick_cnt_r <= tick_cnt_r + {12'h0, cpu_clock_tick};
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_cyc_r <= 20'h0;
    end else if (!reset_pin_oe) begin
      oe_cyc_r <= 20'h0;
    end else if (oe_cyc_r != 20'hFFFFF) begin
      oe_cyc_r <= oe_cyc_r + 20'h1;
    end
  end
  ////////////////////////////////////////////////////////////
  AST_WDG_ENTRY: assert property (watchdog_underflow && cpu_reset_n |=> reset_pin_oe && !cpu_reset_n)
    else $error("watchdog underflow did not pull the pin low");
  AST_PIN_OPEN_DRAIN: assert property (reset_pin_oe |-> reset_pin_o == 1'b0)
    else $error("reset pin driven high");
  AST_HOLD_CPU: assert property (reset_pin_oe |-> !cpu_reset_n)
    else $error("cpu released while pin pulled low");
  AST_DELAY_TICKS: assert property ($fell(oe_d_r) |-> tick_cnt_r >= dly_lo && tick_cnt_r <= dly_lo + 13'h50)
    else $error("delay phase tick count wrong");
  AST_WDG_WIDTH: assert property ($fell(reset_pin_oe) |-> oe_cyc_r >= `CRS_WDG_PULSE_CYC)
    else $error("reset pulse too short");
  AST_FETCH_START: assert property ($fell(reset_pin_oe) |-> ##[0:130] (vector_fetch && vector_addr == 16'hFFFE))
    else $error("no vector fetch after delay phase");
  AST_FETCH_PAIR: assert property (vector_fetch && vector_addr == 16'hFFFE |=>
    !vector_fetch ##[0:130] (vector_fetch && vector_addr == 16'hFFFF))
    else $error("second vector byte not fetched");
  AST_RUN_AT_FETCH: assert property ($rose(cpu_reset_n) |-> vector_fetch && vector_addr == 16'hFFFF)
    else $error("cpu released away from last fetch");
  AST_EXT_ASYNC: assert property ($fell(reset_pin_i) && cpu_reset_n && !reset_pin_oe |-> ##[0:4] !cpu_reset_n)
    else $error("external reset not entered");
  AST_OSC_KEPT: assert property (reset_pin_oe && $past(reset_pin_oe) |-> $stable(osc_enable))
    else $error("oscillator enable changed in reset");
  COV_WDG: cover property (watchdog_underflow && cpu_reset_n);
  COV_EXT: cover property ($fell(reset_pin_i) && cpu_reset_n);
  COV_RUN: cover property ($rose(cpu_reset_n));
endmodule

bind crs_top crs_top_sva u_sva (.pclk(pclk), .presetn(presetn), .opt_long_delay(opt_long_delay),
  .osc_enable(osc_enable), .reset_pin_i(reset_pin_i), .reset_pin_o(reset_pin_o), .reset_pin_oe(reset_pin_oe),
  .watchdog_underflow(watchdog_underflow), .cpu_clock_tick(cpu_clock_tick), .cpu_reset_n(cpu_reset_n),
  .vector_addr(vector_addr), .vector_fetch(vector_fetch));

// ### crs_far_side.sv
// External reset circuitry, pulled-up reset wire, oscillator source and watchdog.
// Assumes requests from the bench change right after a pclk edge.
`timescale 1ns/1ps
module crs_far_side (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hold_low,
  input wire logic wdg_req,
  input wire logic reset_pin_o,
  input wire logic reset_pin_oe,
  output logic reset_pin_i,
  output logic watchdog_underflow,
  output logic osc_clk
);
  logic req_d_r;
  initial osc_clk = 1'b0;
  // Free-running 3.125 MHz source, present before any release
  always #160 osc_clk = ~osc_clk;
  // Open-drain wire with weak pull-up
  assign reset_pin_i = (hold_low || (reset_pin_oe && !reset_pin_o)) ? 1'b0 : 1'b1;
  // One-cycle underflow pulse per request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_d_r <= 1'b0;
      watchdog_underflow <= 1'b0;
    end else begin
      req_d_r <= wdg_req;
      watchdog_underflow <= wdg_req && !req_d_r;
    end
  end
endmodule

// ### crs_tb.sv
// Self-checking bench for crs_top: APB tasks, reset sequences, clock selection.
// Assumes crs_far_side models the reset wire, oscillator and watchdog.
`timescale 1ns/1ps
`include "crs_params.svh"
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, last_err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic opt_pll_en, opt_long_delay, res_out, pin_i, pin_o, pin_oe, wdg_uf, tick, cpu_rst_n, vfetch;
  logic [2:0] opt_osc_sel;
  logic [3:0] osc_en;
  logic [15:0] vaddr;
  logic hold_low, wdg_req, osc_clk, oe_d;
  int fail_count, check_count, cyc, ticks, oe_ticks, t0;
  logic [15:0] vq[$];
  crs_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .opt_pll_en(opt_pll_en),
    .opt_osc_sel(opt_osc_sel), .opt_long_delay(opt_long_delay), .clock_input_pin(osc_clk),
    .resonator_input_pin(osc_clk), .resonator_output_pin(res_out), .osc_enable(osc_en), .reset_pin_i(pin_i),
    .reset_pin_o(pin_o), .reset_pin_oe(pin_oe), .watchdog_underflow(wdg_uf), .cpu_clock_tick(tick),
    .cpu_reset_n(cpu_rst_n), .vector_addr(vaddr), .vector_fetch(vfetch));
  crs_far_side u_far (.pclk(pclk), .presetn(presetn), .hold_low(hold_low), .wdg_req(wdg_req),
    .reset_pin_o(pin_o), .reset_pin_oe(pin_oe), .reset_pin_i(pin_i), .watchdog_underflow(wdg_uf),
    .osc_clk(osc_clk));
  initial pclk = 1'b0;
  always #4 pclk = ~pclk;
  ////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Waits for a full sequence; extra = ticks of a watchdog active phase
  task automatic wait_run(input int extra);
    int n;
    n = 0;
    while (cpu_rst_n !== 1'b0 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    n = 0;
    while (cpu_rst_n !== 1'b1 && n < 30000) begin
      @(posedge pclk);
      n++;
    end
    @(negedge pclk);
    check("vector count", 32'(vq.size()), 32'h2);
    check("vector low", {16'h0, vq[0]}, 32'h0000FFFE);
    check("vector high", {16'h0, vq[1]}, 32'h0000FFFF);
    check("delay ticks", 32'((oe_ticks >= 256 + extra) && (oe_ticks <= 259 + extra)), 32'h1);
    vq.delete();
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (vfetch === 1'b1) vq.push_back(vaddr);
    if (tick === 1'b1) ticks++;
    if (tick === 1'b1 && oe_d === 1'b1) oe_ticks++;
    oe_d = pin_oe;
    if (cyc >= 80000) begin
      fail_count++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {opt_pll_en, opt_long_delay, wdg_req} = '0;
    opt_osc_sel = 3'h1;
    hold_low = 1'b1;
    {fail_count, check_count, cyc, ticks, oe_ticks} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `CRS_OFS_SYS_STATUS, 32'h0);
    check("status reset", rd, 32'h0);
    apb(1'b0, `CRS_OFS_EVT_STATUS, 32'h0);
    check("events reset", rd, 32'h0);
    repeat (30) @(posedge pclk);
    hold_low <= 1'b0;
    wait_run(0);
    apb(1'b0, `CRS_OFS_SEQ_INFO, 32'h0);
    check("sequence info", rd, 32'h0000_0410);
    $display("test power-up done");
    for (int s = 0; s < 5; s++) begin
      opt_osc_sel <= 3'(s);
      repeat (6) @(posedge pclk);
      check("osc enable", {28'h0, osc_en}, (s == 0) ? 32'h0 : (32'h1 << (s - 1)));
    end
    @(negedge pclk);
    t0 = ticks;
    repeat (800) @(negedge pclk);
    check("tick rate", 32'(ticks - t0), 32'd10);
    opt_pll_en <= 1'b1;
    opt_osc_sel <= 3'h0;
    repeat (200) @(negedge pclk);
    t0 = ticks;
    repeat (400) @(negedge pclk);
    check("pll tick rate", 32'((ticks - t0 >= 19) && (ticks - t0 <= 21)), 32'h1);
    opt_pll_en <= 1'b0;
    opt_osc_sel <= 3'h1;
    repeat (100) @(posedge pclk);
    $display("test clock select done");
    apb(1'b1, `CRS_OFS_EVT_MASK, 32'h1);
    oe_ticks = 0;
    wdg_req <= 1'b1;
    wait_run(1);
    wdg_req <= 1'b0;
    apb(1'b0, `CRS_OFS_SYS_STATUS, 32'h0);
    check("watchdog flag", rd, 32'h1);
    apb(1'b0, `CRS_OFS_EVT_STATUS, 32'h0);
    check("events after watchdog", rd, 32'h5);
    check("irq raised", {31'h0, irq}, 32'h1);
    apb(1'b1, `CRS_OFS_SYS_STATUS, 32'h1);
    apb(1'b0, `CRS_OFS_SYS_STATUS, 32'h0);
    check("flag kept", rd, 32'h1);
    apb(1'b1, `CRS_OFS_SYS_STATUS, 32'h0);
    apb(1'b0, `CRS_OFS_SYS_STATUS, 32'h0);
    check("flag cleared", rd, 32'h0);
    apb(1'b1, `CRS_OFS_EVT_STATUS, 32'h5);
    apb(1'b0, `CRS_OFS_EVT_STATUS, 32'h0);
    check("events cleared", rd, 32'h0);
    check("irq cleared", {31'h0, irq}, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped data", rd, 32'h0);
    check("unmapped error", {31'h0, last_err}, 32'h1);
    $display("test watchdog done");
    apb(1'b1, `CRS_OFS_EVT_MASK, 32'h0);
    oe_ticks = 0;
    hold_low <= 1'b1;
    repeat (3) @(posedge pclk);
    hold_low <= 1'b0;
    wait_run(0);
    apb(1'b0, `CRS_OFS_EVT_STATUS, 32'h0);
    check("events after external", rd, 32'h6);
    apb(1'b0, `CRS_OFS_SYS_STATUS, 32'h0);
    check("flag after external", rd, 32'h0);
    check("irq masked", {31'h0, irq}, 32'h0);
    $display("test external reset done");
    complete_run();
  end
endmodule
